/* File: pga_volume_register_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pvb_cfg.svh"

module pga_volume_register_bank_test;

    // ==========================================
    // stimulus and observation
    logic                       ref_clk_in;
    logic                       rst_n_in;
    logic [`PVB_ADDR_W-1:0]     reg_addr_in;
    logic [`PVB_DATA_W-1:0]     reg_wdata_in;
    logic                       reg_wr_in;
    logic                       reg_rd_in;
    logic [`PVB_DATA_W-1:0]     reg_rdata_out;
    logic [`PVB_NUM_CH-1:0]     zc_event_in;
    pvb_pkg::pvb_in_ctrl_t      input_pair1_right_amp;
    pvb_pkg::pvb_in_ctrl_t      input_pair2_left_amp;
    pvb_pkg::pvb_in_ctrl_t      input_pair2_right_amp;
    pvb_pkg::pvb_hp_ctrl_t      hpl;
    pvb_pkg::pvb_hp_ctrl_t      hpr;
    logic [2:0]                 strobes;
    logic [15:0]                rd_val;
    int                         errors;
    int                         samples_checked;

    pvb_volume_bank DUT (
        .ref_clk_in                  (ref_clk_in),
        .rst_n_in                    (rst_n_in),
        .reg_addr_in                 (reg_addr_in),
        .reg_wdata_in                (reg_wdata_in),
        .reg_wr_in                   (reg_wr_in),
        .reg_rd_in                   (reg_rd_in),
        .reg_rdata_out               (reg_rdata_out),
        .zc_event_in                 (zc_event_in),
        .in_pair1_right_out          (input_pair1_right_amp),
        .in_pair2_left_out           (input_pair2_left_amp),
        .in_pair2_right_out          (input_pair2_right_amp),
        .headphone_left_out          (hpl),
        .headphone_right_out         (hpr),
        .in_pair1_update_strobe_out  (strobes[2]),
        .in_pair2_update_strobe_out  (strobes[1]),
        .headphone_update_strobe_out (strobes[0])
    );

    always #12.5 ref_clk_in = ~ref_clk_in;

    // ==========================================
    // bus and compare helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // returns just after the taking edge has landed
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        rd_val = reg_rdata_out;
    endtask

    task automatic pulse_zc(input int ch);
        @(posedge ref_clk_in);
        zc_event_in <= 5'h01 << ch;
        @(posedge ref_clk_in);
        zc_event_in <= 5'h00;
        #1;
    endtask

    // ==========================================
    // scenarios
    task automatic t_reset;
        logic [7:0]  ofs [5];
        logic [15:0] exp [5];
        ofs = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
        exp = '{16'h008B, 16'h008B, 16'h008B, 16'h006D, 16'h006D};
        chk("input_pair1_right_amp reset", 16'(input_pair1_right_amp), 16'h004B);
        chk("input_pair2_left_amp reset", 16'(input_pair2_left_amp), 16'h004B);
        chk("input_pair2_right_amp reset", 16'(input_pair2_right_amp), 16'h004B);
        chk("hpl reset", 16'(hpl), 16'h006D);
        chk("hpr reset", 16'(hpr), 16'h006D);
        chk("strobes reset", 16'(strobes), 16'h0000);
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i]);
            chk("reset readback", rd_val, exp[i]);
        end
        $display("test reset values done");
    endtask

    task automatic t_pair2;
        wr(8'h19, 16'h0005);
        chk("input_pair2_left_amp held", 16'(input_pair2_left_amp), 16'h000B);
        chk("no strobe", 16'(strobes), 16'h0000);
        rd(8'h19);
        chk("input_pair2_left_amp readback", rd_val, 16'h0005);
        wr(8'h1B, 16'h011F);
        chk("pair2 strobe", 16'(strobes), 16'h0002);
        chk("input_pair2_left_amp applied", 16'(input_pair2_left_amp), 16'h0005);
        chk("input_pair2_right_amp applied", 16'(input_pair2_right_amp), 16'h001F);
        @(posedge ref_clk_in);
        #1;
        chk("strobe drops", 16'(strobes), 16'h0000);
        wr(8'h19, 16'h0107);
        chk("pair2 strobe from left", 16'(strobes), 16'h0002);
        chk("input_pair2_left_amp from left", 16'(input_pair2_left_amp), 16'h0007);
        chk("input_pair2_right_amp from left", 16'(input_pair2_right_amp), 16'h001F);
        $display("test second input pair done");
    endtask

    task automatic t_pair1;
        wr(8'h1A, 16'h0110);
        chk("pair1 strobe", 16'(strobes), 16'h0004);
        chk("input_pair1_right_amp applied", 16'(input_pair1_right_amp), 16'h0010);
        rd(8'h1A);
        chk("input_pair1_right_amp readback", rd_val, 16'h0010);
        $display("test first input pair done");
    endtask

    task automatic t_headphone;
        wr(8'h1C, 16'h0020);
        chk("hpl muted held", 16'(hpl), 16'h002D);
        wr(8'h1D, 16'h017F);
        chk("hp strobe", 16'(strobes), 16'h0001);
        chk("hpl applied", 16'(hpl), 16'h0020);
        chk("hpr applied", 16'(hpr), 16'h007F);
        rd(8'h1D);
        chk("hpr readback", rd_val, 16'h007F);
        wr(8'h1C, 16'h0125);
        chk("hpl from left", 16'(hpl), 16'h0025);
        chk("hp strobe from left", 16'(strobes), 16'h0001);
        chk("hpr kept", 16'(hpr), 16'h007F);
        $display("test headphone pair done");
    endtask

    task automatic t_zero_cross;
        wr(8'h1C, 16'h01C0);
        chk("hpl waits", 16'(hpl), 16'h00E5);
        chk("hpr unaffected", 16'(hpr), 16'h007F);
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk("hpl still waits", 16'(hpl), 16'h00E5);
        pulse_zc(`PVB_CH_HPL);
        chk("hpl at crossing", 16'(hpl), 16'h00C0);
        wr(8'h1A, 16'h0141);
        chk("input_pair1_right_amp waits", 16'(input_pair1_right_amp), 16'h0030);
        pulse_zc(`PVB_CH_INPUT_PAIR1_RIGHT_AMP);
        chk("input_pair1_right_amp at crossing", 16'(input_pair1_right_amp), 16'h0021);
        $display("test zero cross done");
    endtask

    task automatic t_unmapped;
        wr(8'h1E, 16'hFFFF);
        rd(8'h1E);
        chk("unmapped read", rd_val, 16'h0000);
        wr(8'h1B, 16'hFEFF);
        chk("input_pair2_right_amp flags only", 16'(input_pair2_right_amp), 16'h007F);
        chk("no strobe", 16'(strobes), 16'h0000);
        rd(8'h1B);
        chk("reserved bits", rd_val, 16'h00DF);
        wr(8'h1D, 16'h007A);
        chk("hpr held", 16'(hpr), 16'h007F);
        rd(8'h1D);
        chk("hpr held readback", rd_val, 16'h007A);
        $display("test reserved and unmapped done");
    endtask

    // ==========================================
    // verdict, reached from the sequence or the watchdog
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in      = 1'b0;
        rst_n_in        = 1'b0;
        reg_addr_in     = 8'h00;
        reg_wdata_in    = 16'h0000;
        reg_wr_in       = 1'b0;
        reg_rd_in       = 1'b0;
        zc_event_in     = 5'h00;
        errors          = 0;
        samples_checked = 0;
        repeat (10) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        t_reset();
        t_pair2();
        t_pair1();
        t_headphone();
        t_zero_cross();
        t_unmapped();
        end_of_test();
    end

    // whole sequence needs about sixty-five cycles
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        errors++;
        end_of_test();
    end

endmodule

`default_nettype wire

/* File: pvb_cfg.svh */
// Summary of operation
// - Writing 1 to bit 8 of either second input pair register applies both pending pair gains together.
// - Writing 1 to bit 8 of the first input pair register applies the gain of that register alone.
// - Writing 1 to bit 8 of either headphone register applies both headphone gains together.
// - The second input pair's and the headphone pair's update bit sits in both their left and right registers and either one fires it.
// - Input mute bit 7 mutes at 1, passes at 0, and resets to 1.
// - Input zero-cross bit 6 changes gain at once at 0, waits for a crossing at 1, resets to 0.
// - Input gain bits 4:0 run from -16.5dB upward in 1.5dB steps and reset to code 0_1011.
// - Headphone bit 6 is an active-low mute: 0 mutes, 1 un-mutes, reset value 1.
// - Headphone zero-cross bit 7 at 1 makes gain changes wait for a crossing, resets to 0.
// - Headphone gain bits 5:0 run from -57dB at code 0 to +6dB at code 3F in 1dB steps.
// - Both headphone gain fields reset to code 10_1101.
`ifndef PVB_CFG_SVH
`define PVB_CFG_SVH

// ==========================================
// bus geometry
`define PVB_ADDR_W        8
`define PVB_DATA_W        16
`define PVB_NUM_CH        5

// ==========================================
// register offsets
`define PVB_OFS_INPUT_PAIR2_LEFT_AMP      8'h19
`define PVB_OFS_INPUT_PAIR1_RIGHT_AMP      8'h1A
`define PVB_OFS_INPUT_PAIR2_RIGHT_AMP      8'h1B
`define PVB_OFS_HPL       8'h1C
`define PVB_OFS_HPR       8'h1D

// ==========================================
// channel index
`define PVB_CH_INPUT_PAIR1_RIGHT_AMP       0
`define PVB_CH_INPUT_PAIR2_LEFT_AMP       1
`define PVB_CH_INPUT_PAIR2_RIGHT_AMP       2
`define PVB_CH_HPL        3
`define PVB_CH_HPR        4

// ==========================================
// field positions
`define PVB_BIT_UPDATE    8
`define PVB_FLAGS_HI      7
`define PVB_FLAGS_LO      6
`define PVB_IN_GAIN_W     5
`define PVB_HP_GAIN_W     6

// ==========================================
// reset values
`define PVB_RST_IN_GAIN   5'h0B
`define PVB_RST_HP_GAIN   6'h2D
`define PVB_RST_IN_FLAGS  2'h2
`define PVB_RST_HP_FLAGS  2'h1

`endif

/* File: pvb_gain_stage.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pvb_cfg.svh"

module pvb_gain_stage #(
    parameter int unsigned          GAIN_W   = 6,
    parameter logic [GAIN_W-1:0]    GAIN_RST = '0
) (
    // clock and reset
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    // register side
    input  wire logic               wr_in,
    input  wire logic [GAIN_W-1:0]  gain_in,
    input  wire logic               update_in,
    input  wire logic               zc_enable_in,
    input  wire logic               zc_event_in,
    // amplifier side
    output logic      [GAIN_W-1:0]  held_gain_out,
    output logic      [GAIN_W-1:0]  applied_gain_out,
    output logic                    pending_out
);

    logic [GAIN_W-1:0] held_reg;
    logic [GAIN_W-1:0] staged_reg;
    logic [GAIN_W-1:0] applied_reg;
    logic              pending_reg;

    // ==========================================
    // next state
    // the value captured at update is staged, so a later write without
    // update cannot slip out while a crossing is awaited
    wire logic [GAIN_W-1:0] held_next    = wr_in ? gain_in : held_reg;
    wire logic [GAIN_W-1:0] staged_next  = update_in ? held_next : staged_reg;
    wire logic              want_apply   = update_in | pending_reg;
    wire logic              apply_now    = want_apply & (~zc_enable_in | zc_event_in);
    wire logic              pending_next = want_apply & ~apply_now;
    wire logic [GAIN_W-1:0] applied_next = apply_now ? staged_next : applied_reg;

    // ==========================================
    // registers
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            held_reg    <= GAIN_RST;
            staged_reg  <= GAIN_RST;
            applied_reg <= GAIN_RST;
            pending_reg <= 1'b0;
        end else begin
            held_reg    <= held_next;
            staged_reg  <= staged_next;
            applied_reg <= applied_next;
            pending_reg <= pending_next;
        end
    end

    assign held_gain_out    = held_reg;
    assign applied_gain_out = applied_reg;
    assign pending_out      = pending_reg;

endmodule

`default_nettype wire

/* File: pvb_pkg.sv */
`default_nettype none
`include "pvb_cfg.svh"

package pvb_pkg;

    // input amplifier settings as applied
    typedef struct packed {
        logic                        mute;
        logic                        zero_cross;
        logic [`PVB_IN_GAIN_W-1:0]   gain;
    } pvb_in_ctrl_t;

    // headphone amplifier settings as applied
    typedef struct packed {
        logic                        zero_cross;
        logic                        unmute;
        logic [`PVB_HP_GAIN_W-1:0]   gain;
    } pvb_hp_ctrl_t;

endpackage

`default_nettype wire

/* File: pvb_volume_bank.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pvb_cfg.svh"

module pvb_volume_bank (
    // clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       rst_n_in,
    // register port
    input  wire logic [`PVB_ADDR_W-1:0]     reg_addr_in,
    input  wire logic [`PVB_DATA_W-1:0]     reg_wdata_in,
    input  wire logic                       reg_wr_in,
    input  wire logic                       reg_rd_in,
    output logic      [`PVB_DATA_W-1:0]     reg_rdata_out,
    // zero-cross events, one per channel, indexed by channel
    input  wire logic [`PVB_NUM_CH-1:0]     zc_event_in,
    // applied amplifier settings
    output pvb_pkg::pvb_in_ctrl_t           in_pair1_right_out,
    output pvb_pkg::pvb_in_ctrl_t           in_pair2_left_out,
    output pvb_pkg::pvb_in_ctrl_t           in_pair2_right_out,
    output pvb_pkg::pvb_hp_ctrl_t           headphone_left_out,
    output pvb_pkg::pvb_hp_ctrl_t           headphone_right_out,
    // update strobes, one cycle after the triggering write
    output logic                            in_pair1_update_strobe_out,
    output logic                            in_pair2_update_strobe_out,
    output logic                            headphone_update_strobe_out
);

    // ==========================================
    // address decode
    wire logic sel_input_pair1_right_amp = (reg_addr_in == `PVB_OFS_INPUT_PAIR1_RIGHT_AMP);
    wire logic sel_input_pair2_left_amp = (reg_addr_in == `PVB_OFS_INPUT_PAIR2_LEFT_AMP);
    wire logic sel_input_pair2_right_amp = (reg_addr_in == `PVB_OFS_INPUT_PAIR2_RIGHT_AMP);
    wire logic sel_hpl  = (reg_addr_in == `PVB_OFS_HPL);
    wire logic sel_hpr  = (reg_addr_in == `PVB_OFS_HPR);

    wire logic [`PVB_NUM_CH-1:0] wr_ch = {5{reg_wr_in}} &
                                         {sel_hpr, sel_hpl, sel_input_pair2_right_amp, sel_input_pair2_left_amp, sel_input_pair1_right_amp};

    wire logic upd_bit = reg_wdata_in[`PVB_BIT_UPDATE];

    // either register of a pair fires the shared update
    wire logic upd_in1 = wr_ch[`PVB_CH_INPUT_PAIR1_RIGHT_AMP] & upd_bit;
    wire logic upd_in2 = (wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP] | wr_ch[`PVB_CH_INPUT_PAIR2_RIGHT_AMP]) & upd_bit;
    wire logic upd_hp  = (wr_ch[`PVB_CH_HPL] | wr_ch[`PVB_CH_HPR]) & upd_bit;

    wire logic [`PVB_NUM_CH-1:0] upd_ch = {upd_hp, upd_hp, upd_in2, upd_in2, upd_in1};

    wire logic [1:0] wflags = reg_wdata_in[`PVB_FLAGS_HI:`PVB_FLAGS_LO];

    // ==========================================
    // per-channel flags and gain stages
    logic [1:0]                   flags_reg   [`PVB_NUM_CH];
    logic [`PVB_HP_GAIN_W-1:0]    held_gain   [`PVB_NUM_CH];
    logic [`PVB_HP_GAIN_W-1:0]    applied_gain[`PVB_NUM_CH];
    logic [`PVB_NUM_CH-1:0]       pending;

    genvar gi;
    generate
        // input channels: flags are {mute, zero_cross}
        for (gi = `PVB_CH_INPUT_PAIR1_RIGHT_AMP; gi <= `PVB_CH_INPUT_PAIR2_RIGHT_AMP; gi++) begin : g_in
            logic [`PVB_IN_GAIN_W-1:0] held_w;
            logic [`PVB_IN_GAIN_W-1:0] applied_w;
            // a zero-cross bit set by the same write already governs that update
            wire logic                 zc_en = wr_ch[gi] ? wflags[0] : flags_reg[gi][0];

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    flags_reg[gi] <= `PVB_RST_IN_FLAGS;
                end else if (wr_ch[gi]) begin
                    flags_reg[gi] <= wflags;
                end
            end

            pvb_gain_stage #(
                .GAIN_W   (`PVB_IN_GAIN_W),
                .GAIN_RST (`PVB_RST_IN_GAIN)
            ) u_stage (
                .ref_clk_in       (ref_clk_in),
                .rst_n_in         (rst_n_in),
                .wr_in            (wr_ch[gi]),
                .gain_in          (reg_wdata_in[`PVB_IN_GAIN_W-1:0]),
                .update_in        (upd_ch[gi]),
                .zc_enable_in     (zc_en),
                .zc_event_in      (zc_event_in[gi]),
                .held_gain_out    (held_w),
                .applied_gain_out (applied_w),
                .pending_out      (pending[gi])
            );

            assign held_gain[gi]    = {1'b0, held_w};
            assign applied_gain[gi] = {1'b0, applied_w};
        end

        // headphone channels: flags are {zero_cross, unmute}
        for (gi = `PVB_CH_HPL; gi <= `PVB_CH_HPR; gi++) begin : g_hp
            // enable sits in bit 7 here; the written word's value counts at once
            wire logic zc_en = wr_ch[gi] ? wflags[1] : flags_reg[gi][1];

            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    flags_reg[gi] <= `PVB_RST_HP_FLAGS;
                end else if (wr_ch[gi]) begin
                    flags_reg[gi] <= wflags;
                end
            end

            pvb_gain_stage #(
                .GAIN_W   (`PVB_HP_GAIN_W),
                .GAIN_RST (`PVB_RST_HP_GAIN)
            ) u_stage (
                .ref_clk_in       (ref_clk_in),
                .rst_n_in         (rst_n_in),
                .wr_in            (wr_ch[gi]),
                .gain_in          (reg_wdata_in[`PVB_HP_GAIN_W-1:0]),
                .update_in        (upd_ch[gi]),
                .zc_enable_in     (zc_en),
                .zc_event_in      (zc_event_in[gi]),
                .held_gain_out    (held_gain[gi]),
                .applied_gain_out (applied_gain[gi]),
                .pending_out      (pending[gi])
            );
        end
    endgenerate

    // ==========================================
    // read mux: update bit and reserved bits read as zero
    function automatic logic [`PVB_DATA_W-1:0] pack_word(input logic [1:0] fl,
                                                        input logic [5:0] g);
        pack_word = {8'h00, fl, 6'h00} | {10'h000, g};
    endfunction

    wire logic [`PVB_DATA_W-1:0] rd_input_pair1_right_amp = pack_word(flags_reg[`PVB_CH_INPUT_PAIR1_RIGHT_AMP],
                                                    held_gain[`PVB_CH_INPUT_PAIR1_RIGHT_AMP]);
    wire logic [`PVB_DATA_W-1:0] rd_input_pair2_left_amp = pack_word(flags_reg[`PVB_CH_INPUT_PAIR2_LEFT_AMP],
                                                    held_gain[`PVB_CH_INPUT_PAIR2_LEFT_AMP]);
    wire logic [`PVB_DATA_W-1:0] rd_input_pair2_right_amp = pack_word(flags_reg[`PVB_CH_INPUT_PAIR2_RIGHT_AMP],
                                                    held_gain[`PVB_CH_INPUT_PAIR2_RIGHT_AMP]);
    wire logic [`PVB_DATA_W-1:0] rd_hpl  = pack_word(flags_reg[`PVB_CH_HPL],
                                                    held_gain[`PVB_CH_HPL]);
    wire logic [`PVB_DATA_W-1:0] rd_hpr  = pack_word(flags_reg[`PVB_CH_HPR],
                                                    held_gain[`PVB_CH_HPR]);

    // unmapped addresses read zero
    wire logic [`PVB_DATA_W-1:0] rd_mux =
        sel_input_pair1_right_amp ? rd_input_pair1_right_amp :
        sel_input_pair2_left_amp ? rd_input_pair2_left_amp :
        sel_input_pair2_right_amp ? rd_input_pair2_right_amp :
        sel_hpl  ? rd_hpl  :
        sel_hpr  ? rd_hpr  : 16'h0000;

    // data stand only in the cycle after the read strobe
    wire logic [`PVB_DATA_W-1:0] rdata_next = reg_rd_in ? rd_mux : 16'h0000;

    logic [`PVB_DATA_W-1:0] rdata_reg;
    logic                   upd_in1_reg;
    logic                   upd_in2_reg;
    logic                   upd_hp_reg;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata_reg   <= 16'h0000;
            upd_in1_reg <= 1'b0;
            upd_in2_reg <= 1'b0;
            upd_hp_reg  <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            upd_in1_reg <= upd_in1;
            upd_in2_reg <= upd_in2;
            upd_hp_reg  <= upd_hp;
        end
    end

    // ==========================================
    // outputs, all straight from flops
    assign reg_rdata_out               = rdata_reg;
    assign in_pair1_update_strobe_out  = upd_in1_reg;
    assign in_pair2_update_strobe_out  = upd_in2_reg;
    assign headphone_update_strobe_out = upd_hp_reg;

    assign in_pair1_right_out  = {flags_reg[`PVB_CH_INPUT_PAIR1_RIGHT_AMP],
                                  applied_gain[`PVB_CH_INPUT_PAIR1_RIGHT_AMP][`PVB_IN_GAIN_W-1:0]};
    assign in_pair2_left_out   = {flags_reg[`PVB_CH_INPUT_PAIR2_LEFT_AMP],
                                  applied_gain[`PVB_CH_INPUT_PAIR2_LEFT_AMP][`PVB_IN_GAIN_W-1:0]};
    assign in_pair2_right_out  = {flags_reg[`PVB_CH_INPUT_PAIR2_RIGHT_AMP],
                                  applied_gain[`PVB_CH_INPUT_PAIR2_RIGHT_AMP][`PVB_IN_GAIN_W-1:0]};
    assign headphone_left_out  = {flags_reg[`PVB_CH_HPL], applied_gain[`PVB_CH_HPL]};
    assign headphone_right_out = {flags_reg[`PVB_CH_HPR], applied_gain[`PVB_CH_HPR]};

    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    wire logic wr_input_pair2_right_amp_now = wr_ch[`PVB_CH_INPUT_PAIR2_RIGHT_AMP] & upd_bit & ~reg_wdata_in[`PVB_FLAGS_LO]
                             & ~flags_reg[`PVB_CH_INPUT_PAIR2_LEFT_AMP][0];
    wire logic wr_input_pair1_right_amp_now = wr_ch[`PVB_CH_INPUT_PAIR1_RIGHT_AMP] & upd_bit & ~reg_wdata_in[`PVB_FLAGS_LO];
    wire logic wr_hpl_now  = wr_ch[`PVB_CH_HPL] & upd_bit & ~reg_wdata_in[`PVB_FLAGS_HI]
                             & ~flags_reg[`PVB_CH_HPR][1];

    pair2_together_a: assert property (wr_input_pair2_right_amp_now |=>
        in_pair2_right_out.gain == $past(reg_wdata_in[4:0]) &&
        in_pair2_left_out.gain == $past(held_gain[`PVB_CH_INPUT_PAIR2_LEFT_AMP][4:0]) &&
        in_pair2_update_strobe_out)
        else $error("second input pair did not update together");

    pair1_update_a: assert property (wr_input_pair1_right_amp_now |=>
        in_pair1_right_out.gain == $past(reg_wdata_in[4:0]) && in_pair1_update_strobe_out)
        else $error("first input pair update missed");

    hp_together_a: assert property (wr_hpl_now |=>
        headphone_left_out.gain == $past(reg_wdata_in[5:0]) &&
        headphone_right_out.gain == $past(held_gain[`PVB_CH_HPR]) &&
        headphone_update_strobe_out)
        else $error("headphone pair did not update together");

    either_reg_fires_a: assert property (
        (wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP] | wr_ch[`PVB_CH_HPR]) && upd_bit |=>
        in_pair2_update_strobe_out == $past(wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP]) &&
        headphone_update_strobe_out == $past(wr_ch[`PVB_CH_HPR]) ##1
        !(in_pair2_update_strobe_out & headphone_update_strobe_out))
        else $error("update bit in one register of a pair ignored");

    in_reset_vals_a: assert property ($past(!rst_n_in) |->
        in_pair2_left_out.mute && !in_pair2_left_out.zero_cross &&
        in_pair1_right_out.gain == `PVB_RST_IN_GAIN)
        else $error("input channel reset values wrong");

    hp_reset_vals_a: assert property ($past(!rst_n_in) |->
        headphone_left_out.unmute && !headphone_right_out.zero_cross &&
        headphone_left_out.gain == `PVB_RST_HP_GAIN &&
        headphone_right_out.gain == `PVB_RST_HP_GAIN)
        else $error("headphone reset values wrong");

    hold_no_update_a: assert property (
        wr_ch[`PVB_CH_HPR] && !upd_bit && !pending[`PVB_CH_HPR] |=>
        $stable(headphone_right_out.gain) ##1
        (pending[`PVB_CH_HPR] || headphone_update_strobe_out ||
         $stable(headphone_right_out.gain)))
        else $error("gain reached amplifier without update");

    zc_wait_a: assert property (
        pending[`PVB_CH_HPL] && flags_reg[`PVB_CH_HPL][1] &&
        !zc_event_in[`PVB_CH_HPL] && !wr_ch[`PVB_CH_HPL] |=>
        $stable(headphone_left_out.gain))
        else $error("gain changed before zero crossing");

    update_reads_zero_a: assert property (reg_rd_in |=>
        reg_rdata_out[`PVB_DATA_W-1:`PVB_BIT_UPDATE] == 8'h00 ##1
        (reg_rdata_out == 16'h0000 || $past(reg_rd_in)))
        else $error("update bit or upper bits read nonzero");

    hp_readback_a: assert property (reg_rd_in && sel_hpl |=>
        reg_rdata_out[5:0] == $past(held_gain[`PVB_CH_HPL]) &&
        reg_rdata_out[7:6] == $past(flags_reg[`PVB_CH_HPL]))
        else $error("headphone readback wrong");

    // flags act on the write edge; only gains wait for an update
    mute_immediate_a: assert property (wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP] |=>
        in_pair2_left_out.mute == $past(reg_wdata_in[`PVB_FLAGS_HI]))
        else $error("input mute did not follow the write");

    hp_unmute_a: assert property (wr_ch[`PVB_CH_HPR] |=>
        headphone_right_out.unmute == $past(reg_wdata_in[`PVB_FLAGS_LO]))
        else $error("headphone unmute did not follow the write");

    in_gain_held_a: assert property (
        wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP] && !upd_bit && !pending[`PVB_CH_INPUT_PAIR2_LEFT_AMP] |=>
        $stable(in_pair2_left_out.gain))
        else $error("input gain moved without update");

    in1_zc_wait_a: assert property (
        pending[`PVB_CH_INPUT_PAIR1_RIGHT_AMP] && flags_reg[`PVB_CH_INPUT_PAIR1_RIGHT_AMP][0] &&
        !zc_event_in[`PVB_CH_INPUT_PAIR1_RIGHT_AMP] && !wr_ch[`PVB_CH_INPUT_PAIR1_RIGHT_AMP] |=>
        $stable(in_pair1_right_out.gain))
        else $error("input gain changed before zero crossing");

    zc_release_a: assert property (
        pending[`PVB_CH_HPL] && zc_event_in[`PVB_CH_HPL] |=> !pending[`PVB_CH_HPL])
        else $error("crossing did not release pending gain");

    // strobes carry no state from one write to the next
    no_update_quiet_a: assert property (reg_wr_in && !upd_bit |=>
        !in_pair1_update_strobe_out && !in_pair2_update_strobe_out &&
        !headphone_update_strobe_out)
        else $error("update strobe without update bit");

    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read cycle");

    cov_pair2_c: cover property (wr_input_pair2_right_amp_now ##1 in_pair2_update_strobe_out);
    cov_hp_zc_c: cover property (pending[`PVB_CH_HPL] ##[1:20] !pending[`PVB_CH_HPL]);
    cov_read_c:  cover property (reg_rd_in && sel_input_pair1_right_amp ##1 reg_wr_in);
    cov_pair1_c: cover property (in_pair1_update_strobe_out);
    cov_left_c:  cover property (wr_ch[`PVB_CH_INPUT_PAIR2_LEFT_AMP] && upd_bit ##1 in_pair2_update_strobe_out);

endmodule

`default_nettype wire
